/* design/dtc_params.svh */
// Purpose: constants for the dual 12-bit timer/counter block
// Assumes: sys_clk is the basic clock fc; one instruction cycle is eight fc periods
// Notes:   offsets are 5-bit output port addresses of the core
//
// Overview of operation
// - two independent 12-bit counters, own modes
// - count held as RAM-addressable nibbles, presettable
// - stopped mode leaves nibbles as plain storage
// - command ports 0x1C and 0x1D, reset zero
// - count on rising pulse edge after command
// - increment steals one instruction cycle, holds fetch
// - simultaneous requests: first counter, then second
// - wrap FFF to 000 raises overflow request
// - counting continues from zero after overflow
// - event mode counts external pin rising edges
// - timer mode uses divider taps 2^10..2^22
// - fastest timer rate: one steal per 128 cycles
// - timer mode leaves pins as ordinary ports
// - pulse width counts internal pulses while pin high
// - first counter has no external input pin
// - periodic interrupt at first divider edge after write
// - periodic command write never clears divider
`ifndef DTC_PARAMS_SVH
`define DTC_PARAMS_SVH

`define DTC_CNT_W          12
`define DTC_PORT_W         5
`define DTC_ADDR_PERIODIC  5'h19
`define DTC_ADDR_CTRL_ONE  5'h1C
`define DTC_ADDR_CTRL_TWO  5'h1D
`define DTC_CTRL_RESET     4'h0
`define DTC_PERIODIC_RESET 4'h0
`define DTC_CTRL_MODE_MSB  3
`define DTC_CTRL_MODE_LSB  2
`define DTC_CTRL_RATE_MSB  1
`define DTC_CTRL_RATE_LSB  0
`define DTC_PERIODIC_EN    3
`define DTC_DIV_W          22
`define DTC_TAP_0          9
`define DTC_TAP_1          13
`define DTC_TAP_2          17
`define DTC_TAP_3          21
`define DTC_INSTR_LOG2     3
`define DTC_NIBBLES        3

`endif

/* design/dtc_pkg.sv */
// Purpose: shared types of the dual timer/counter
// Assumes: nothing beyond the constants header
// Notes:   mode codes are the upper two bits of a command nibble
package dtc_pkg;

    typedef enum logic [1:0] {
        DTC_STOP  = 2'b00,
        DTC_EVENT = 2'b01,
        DTC_TIMER = 2'b10,
        DTC_PULSE = 2'b11
    } dtc_mode_t;

    typedef enum logic {
        DTC_IDLE  = 1'b0,
        DTC_COUNT = 1'b1
    } dtc_state_t;

    // output port write from the core
    typedef struct packed {
        logic       en;
        logic [4:0] addr;
        logic [3:0] data;
    } dtc_port_wr_t;

    // RAM access aimed at the count nibbles: idx[2] counter, idx[1:0] nibble
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [2:0] idx;
        logic [3:0] data;
    } dtc_ram_req_t;

endpackage

/* design/dtc_prescaler.sv */
// Purpose: free-running fc divider chain, instruction cycle tick and rate taps
// Assumes: sys_clk is fc
// Notes:   never cleared by any command, only by reset
`timescale 1ns/1ns
`default_nettype none
`include "dtc_params.svh"

module dtc_prescaler
    import dtc_pkg::*;
#(
    parameter int DIV_W = `DTC_DIV_W
) (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       reset,
    // timing outputs
    output logic            instr_tick,
    output logic [3:0]      tap_level,
    output logic [3:0]      tap_rise
);

    localparam int TAPS [4] = '{`DTC_TAP_0, `DTC_TAP_1, `DTC_TAP_2, `DTC_TAP_3};

    logic [DIV_W-1:0] div_ff;
    logic [3:0]       tap_prev_ff;
    logic [3:0]       tap_rise_ff;

    if (DIV_W < `DTC_TAP_3 + 1) begin : g_bad_width
        $error("dtc_prescaler: DIV_W too small for the slowest tap");
    end

    // chain runs free; the periodic command cannot clear it
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            div_ff <= '0;
        end else begin
            div_ff <= div_ff + {{(DIV_W-1){1'b0}}, 1'b1};
        end
    end

    // last fc period of each eight-period instruction cycle
    assign instr_tick = &div_ff[`DTC_INSTR_LOG2-1:0];

    for (genvar t = 0; t < 4; t++) begin : g_tap
        assign tap_level[t] = div_ff[TAPS[t]];
        always_ff @(posedge sys_clk) begin
            if (reset) begin
                tap_prev_ff[t] <= 1'b0;
                tap_rise_ff[t] <= 1'b0;
            end else begin
                tap_prev_ff[t] <= div_ff[TAPS[t]];
                tap_rise_ff[t] <= div_ff[TAPS[t]] & ~tap_prev_ff[t];
            end
        end
    end

    assign tap_rise = tap_rise_ff;

endmodule
`default_nettype wire

/* design/dtc_channel.sv */
// Purpose: one counter's command register and count request source
// Assumes: pin input is asynchronous to sys_clk
// Notes:   the request is a one-cycle pulse; the owner keeps it pending
`timescale 1ns/1ns
`default_nettype none
`include "dtc_params.svh"

module dtc_channel
    import dtc_pkg::*;
#(
    parameter bit HAS_PIN = 1'b1
) (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       reset,
    // command port
    input  wire logic       ctrl_wr,
    input  wire logic [3:0] ctrl_data,
    // count sources
    input  wire logic       count_pin,
    input  wire logic [3:0] tap_rise,
    // results
    output dtc_mode_t       mode,
    output logic            pin_used,
    output logic            count_req
);

    logic [3:0] ctrl_ff;
    logic       pin_meta_ff;
    logic       pin_sync_ff;
    logic       pin_prev_ff;
    logic       rate_rise;
    logic       pin_rise;
    logic       pin_high;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ctrl_ff <= `DTC_CTRL_RESET;
        end else if (ctrl_wr) begin
            ctrl_ff <= ctrl_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pin_meta_ff <= 1'b0;
            pin_sync_ff <= 1'b0;
            pin_prev_ff <= 1'b0;
        end else begin
            pin_meta_ff <= count_pin;
            pin_sync_ff <= pin_meta_ff;
            pin_prev_ff <= pin_sync_ff;
        end
    end

    assign mode      = dtc_mode_t'(ctrl_ff[`DTC_CTRL_MODE_MSB:`DTC_CTRL_MODE_LSB]);
    assign rate_rise = tap_rise[ctrl_ff[`DTC_CTRL_RATE_MSB:`DTC_CTRL_RATE_LSB]];
    // no pin on the first counter: its pin modes never count
    assign pin_rise  = HAS_PIN & pin_sync_ff & ~pin_prev_ff;
    assign pin_high  = HAS_PIN & pin_sync_ff;
    // pin stays an ordinary port in stopped and timer modes
    assign pin_used  = HAS_PIN & ctrl_ff[`DTC_CTRL_MODE_LSB];

    always_comb begin
        case (mode)
            DTC_EVENT: count_req = pin_rise;
            DTC_TIMER: count_req = rate_rise;
            DTC_PULSE: count_req = rate_rise & pin_high;
            default:   count_req = 1'b0;
        endcase
        // an edge coinciding with the command write is not the first after it
        if (ctrl_wr) begin
            count_req = 1'b0;
        end
    end

endmodule
`default_nettype wire

/* design/dtc_timer_counter.sv */
// Purpose: dual 12-bit timer/counter with cycle-stealing increment and periodic interrupt
// Assumes: core flags instruction completion in the instruction cycle that ends it
// Notes:   count nibbles live here and answer the core's RAM accesses for their addresses
`timescale 1ns/1ns
`default_nettype none
`include "dtc_params.svh"

module dtc_timer_counter
    import dtc_pkg::*;
#(
    parameter int CNT_W = `DTC_CNT_W,
    parameter int DIV_W = `DTC_DIV_W
) (
    // clock and reset
    input  wire logic         sys_clk,
    input  wire logic         reset,
    // command port writes from the core
    input  wire dtc_port_wr_t port_wr,
    // RAM accesses to the count nibbles
    input  wire dtc_ram_req_t ram_req,
    output logic [3:0]        ram_rdata,
    // instruction sequencing
    input  wire logic         instr_end,
    output logic              instr_tick,
    output logic              count_stall,
    // external count pin of the second counter
    input  wire logic         second_count_pin,
    output logic [1:0]        pin_used,
    // interrupts
    input  wire logic [1:0]   ovf_ack,
    output logic [1:0]        ovf_irq,
    output logic              periodic_irq
);

    if (CNT_W != `DTC_NIBBLES * 4) begin : g_bad_cnt
        $error("dtc_timer_counter: CNT_W must be three nibbles");
    end

    logic [3:0]     tap_level;
    logic [3:0]     tap_rise;
    dtc_mode_t      mode [2];
    logic [1:0]     count_req;
    logic [1:0]     ctrl_wr;

    logic [CNT_W-1:0] cnt_ff [2];
    logic [1:0]       pend_ff;
    logic [1:0]       ovf_ff;
    dtc_state_t       state_ff;
    dtc_state_t       nxt_state;
    logic             sel_ff;
    logic             nxt_sel;
    logic [1:0]       serviced;
    logic [3:0]       rdata_ff;
    logic [3:0]       periodic_ctrl_ff;
    logic             periodic_ff;

    dtc_prescaler #(
        .DIV_W      (DIV_W)
    ) u_prescaler (
        .sys_clk    (sys_clk),
        .reset      (reset),
        .instr_tick (instr_tick),
        .tap_level  (),
        .tap_rise   (tap_rise)
    );

    assign ctrl_wr[0] = port_wr.en && (port_wr.addr == `DTC_ADDR_CTRL_ONE);
    assign ctrl_wr[1] = port_wr.en && (port_wr.addr == `DTC_ADDR_CTRL_TWO);

    for (genvar i = 0; i < 2; i++) begin : g_ch
        dtc_channel #(
            .HAS_PIN   (i == 1)
        ) u_channel (
            .sys_clk   (sys_clk),
            .reset     (reset),
            .ctrl_wr   (ctrl_wr[i]),
            .ctrl_data (port_wr.data),
            .count_pin ((i == 1) ? second_count_pin : 1'b0),
            .tap_rise  (tap_rise),
            .mode      (mode[i]),
            .pin_used  (pin_used[i]),
            .count_req (count_req[i])
        );

        // pending request: a new one wins over the service that clears it;
        // stopping the counter drops it so the nibbles stay untouched
        always_ff @(posedge sys_clk) begin
            if (reset) begin
                pend_ff[i] <= 1'b0;
            end else if (mode[i] == DTC_STOP) begin
                pend_ff[i] <= 1'b0;
            end else begin
                pend_ff[i] <= (pend_ff[i] & ~serviced[i]) | count_req[i];
            end
        end

        // count nibbles: RAM writes preset them, the increment steps them
        always_ff @(posedge sys_clk) begin
            if (reset) begin
                cnt_ff[i] <= '0;
            end else if (ram_req.wr && ram_req.idx[2] == 1'(i)
                         && ram_req.idx[1:0] < 2'(`DTC_NIBBLES)) begin
                cnt_ff[i][ram_req.idx[1:0]*4 +: 4] <= ram_req.data;
            end else if (serviced[i]) begin
                // wraps to zero and keeps going
                cnt_ff[i] <= cnt_ff[i] + {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end

        // overflow latch: set wins over acceptance in the same cycle
        always_ff @(posedge sys_clk) begin
            if (reset) begin
                ovf_ff[i] <= 1'b0;
            end else if (serviced[i] && (&cnt_ff[i])) begin
                ovf_ff[i] <= 1'b1;
            end else if (ovf_ack[i]) begin
                ovf_ff[i] <= 1'b0;
            end
        end

        // increment lands at the end of the stolen instruction cycle
        assign serviced[i] = (state_ff == DTC_COUNT) && instr_tick && (sel_ff == 1'(i))
                             && (mode[i] != DTC_STOP);
    end

    // count cycle sequencer: one stolen instruction cycle per increment
    always_comb begin
        nxt_state = state_ff;
        nxt_sel   = sel_ff;
        case (state_ff)
            DTC_IDLE: begin
                if (instr_tick && instr_end && (|pend_ff)) begin
                    nxt_state = DTC_COUNT;
                    nxt_sel   = ~pend_ff[0];
                end
            end
            DTC_COUNT: begin
                if (instr_tick) begin
                    // the other counter follows straight on in the next cycle
                    if (sel_ff == 1'b0 && pend_ff[1]) begin
                        nxt_sel = 1'b1;
                    end else if (sel_ff == 1'b1 && (pend_ff[0] | count_req[0])) begin
                        nxt_sel = 1'b0;
                    end else begin
                        nxt_state = DTC_IDLE;
                    end
                end
            end
            default: begin
                nxt_state = DTC_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_ff <= DTC_IDLE;
            sel_ff   <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            sel_ff   <= nxt_sel;
        end
    end

    // fetch and interrupt acceptance wait while the cycle is stolen
    assign count_stall = (state_ff == DTC_COUNT);

    // read back of the nibbles; the unused fourth nibble reads zero
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rdata_ff <= 4'h0;
        end else if (ram_req.rd) begin
            if (ram_req.idx[1:0] < 2'(`DTC_NIBBLES)) begin
                rdata_ff <= cnt_ff[ram_req.idx[2]][ram_req.idx[1:0]*4 +: 4];
            end else begin
                rdata_ff <= 4'h0;
            end
        end
    end

    assign ram_rdata = rdata_ff;
    assign ovf_irq   = ovf_ff;

    // periodic interrupt: bit 3 enables, bits 1:0 pick the divider tap
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            periodic_ctrl_ff <= `DTC_PERIODIC_RESET;
        end else if (port_wr.en && port_wr.addr == `DTC_ADDR_PERIODIC) begin
            periodic_ctrl_ff <= port_wr.data;
        end
    end

    // the chain is not restarted, so the first pulse can come early
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            periodic_ff <= 1'b0;
        end else begin
            periodic_ff <= periodic_ctrl_ff[`DTC_PERIODIC_EN]
                           && tap_rise[periodic_ctrl_ff[1:0]]
                           && !(port_wr.en && port_wr.addr == `DTC_ADDR_PERIODIC);
        end
    end

    assign periodic_irq = periodic_ff;

endmodule
`default_nettype wire

/* dv/dtc_chk.sv */
// Purpose: concurrent checks on the ports of the dual timer/counter
// Assumes: one clock domain, synchronous active high reset
// Notes:   bound from the bench top
`timescale 1ns/1ns
`default_nettype none

module dtc_chk
    import dtc_pkg::*;
(
    // clock and reset
    input wire logic         sys_clk,
    input wire logic         reset,
    // watched ports
    input wire dtc_ram_req_t ram_req,
    input wire logic [3:0]   ram_rdata,
    input wire logic         instr_end,
    input wire logic         instr_tick,
    input wire logic         count_stall,
    input wire logic [1:0]   pin_used,
    input wire logic [1:0]   ovf_ack,
    input wire logic [1:0]   ovf_irq,
    input wire logic         periodic_irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    a_tick_period: assert property (
        instr_tick |=> !instr_tick [*7] ##1 instr_tick) else $error("tick period wrong");
    a_stall_cause: assert property (
        $rose(count_stall) |-> $past(instr_tick) && $past(instr_end)) else $error("stall cause");
    a_stall_len: assert property (
        $rose(count_stall) |-> count_stall [*8]) else $error("stall shorter than a cycle");
    a_stall_end: assert property (
        $fell(count_stall) |-> $past(instr_tick)) else $error("stall ends mid cycle");
    a_ovf_cause: assert property (
        $rose(ovf_irq[0]) || $rose(ovf_irq[1]) |-> $past(count_stall) && $past(instr_tick))
        else $error("overflow outside increment");
    a_ovf_hold0: assert property (
        ovf_irq[0] && !ovf_ack[0] |=> ovf_irq[0]) else $error("overflow one dropped");
    a_ovf_hold1: assert property (
        ovf_irq[1] && !ovf_ack[1] |=> ovf_irq[1]) else $error("overflow two dropped");
    a_no_first_pin: assert property (
        pin_used[0] == 1'b0) else $error("first counter claims a pin");
    a_periodic_pulse: assert property (
        periodic_irq |=> !periodic_irq) else $error("periodic pulse too long");
    a_read_zero: assert property (
        ram_req.rd && ram_req.idx[1:0] == 2'h3 |=> ram_rdata == 4'h0)
        else $error("nibble three not zero");
    a_quiet_reset: assert property (
        $fell(reset) |-> ovf_irq == 2'h0 && !count_stall) else $error("not quiet after reset");
endmodule
`default_nettype wire

/* dv/dtc_core_model.sv */
// Purpose: core and pin source facing the timer/counter
// Assumes: pin_mode is written by nonblocking assignment at the falling edge
// Notes:   pin_mode 0 low, 1 high, 2 toggling with a 64 clock period
`timescale 1ns/1ns
`default_nettype none

module dtc_core_model (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       reset,
    // sequencing from the block
    input  wire logic       instr_tick,
    input  wire logic       count_stall,
    // pin control from the bench
    input  wire logic [1:0] pin_mode,
    // drives into the block
    output logic            instr_end,
    output logic            second_count_pin,
    output logic [7:0]      rises
);
    logic       seen;
    logic [5:0] phase;

    // two-cycle instructions, flag changed a cycle after the tick so it is stable when sampled
    always @(negedge sys_clk) begin
        seen <= instr_tick;
        if (reset) begin
            instr_end <= 1'b0;
        end else if (seen && !count_stall) begin
            instr_end <= ~instr_end;
        end
    end

    always @(negedge sys_clk) begin
        if (reset) begin
            phase <= 6'h00;
            second_count_pin <= 1'b0; // pin read as input, shared latch taken as one
            rises <= 8'h00;
        end else if (pin_mode == 2'h2) begin
            phase <= phase + 6'h01;
            second_count_pin <= phase[5]; // far below fc/32
            if (phase[5] && !second_count_pin) begin
                rises <= rises + 8'h01;
            end
        end else begin
            second_count_pin <= pin_mode[0]; // steady level, slow against the tap
        end
    end
endmodule
`default_nettype wire

/* dv/dual_twelve_bit_timer_counter_bench.sv */
// Purpose: self-checking bench of the dual timer/counter
// Assumes: timer rate 00 keeps the run short
// Notes:   inputs change at the falling edge
`timescale 1ns/1ns
`default_nettype none
`include "dtc_params.svh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; \
    $display("unexpected %s exp %0h got %0h", n, e, g); end end

module dual_twelve_bit_timer_counter_bench;
    import dtc_pkg::*;
    logic         sys_clk, reset, instr_end, instr_tick, count_stall, pin, periodic_irq;
    dtc_port_wr_t port_wr;
    dtc_ram_req_t ram_req;
    logic [3:0]   ram_rdata, d;
    logic [1:0]   pin_used, ovf_ack, ovf_irq, pin_mode;
    logic [7:0]   rises, r0;
    logic [11:0]  v, w;
    int           mismatches, compares, t;

    dtc_timer_counter DUT (.sys_clk(sys_clk), .reset(reset), .port_wr(port_wr),
        .ram_req(ram_req), .ram_rdata(ram_rdata), .instr_end(instr_end),
        .instr_tick(instr_tick), .count_stall(count_stall), .second_count_pin(pin),
        .pin_used(pin_used), .ovf_ack(ovf_ack), .ovf_irq(ovf_irq), .periodic_irq(periodic_irq));
    dtc_core_model CORE (.sys_clk(sys_clk), .reset(reset), .instr_tick(instr_tick),
        .count_stall(count_stall), .pin_mode(pin_mode), .instr_end(instr_end),
        .second_count_pin(pin), .rises(rises));

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic port_write(input logic [4:0] a, input logic [3:0] x);
        @(negedge sys_clk) port_wr = '{1'b1, a, x};
        @(negedge sys_clk) port_wr.en = 1'b0;
    endtask
    task automatic ram_write(input logic [2:0] i, input logic [3:0] x);
        @(negedge sys_clk) ram_req = '{1'b1, 1'b0, i, x};
        @(negedge sys_clk) ram_req.wr = 1'b0;
    endtask
    task automatic ram_read(input logic [2:0] i, output logic [3:0] x);
        @(negedge sys_clk) ram_req = '{1'b0, 1'b1, i, 4'h0};
        @(negedge sys_clk) ram_req.rd = 1'b0;
        x = ram_rdata;
    endtask
    task automatic set_count(input logic c, input logic [11:0] x);
        for (int k = 0; k < 3; k++) ram_write({c, k[1:0]}, x[4*k +: 4]);
    endtask
    task automatic get_count(input logic c, output logic [11:0] x);
        logic [3:0] q;
        for (int k = 0; k < 3; k++) begin
            ram_read({c, k[1:0]}, q);
            x[4*k +: 4] = q;
        end
    endtask
    function automatic logic probe(input int s);
        case (s)
            0: return ovf_irq[0];
            1: return ovf_irq[1];
            2: return count_stall;
            3: return periodic_irq;
            default: return !count_stall;
        endcase
    endfunction
    // bounded wait; t returns the falling edges spent
    task automatic wait_on(input int s, input int lim);
        t = 0;
        while (probe(s) !== 1'b1 && t < lim) begin
            @(negedge sys_clk);
            t++;
        end
        `CHK("wait", 1'b1, probe(s))
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    initial begin
        // slow periodic rate needs two 16384-clock periods on top of the rest
        #(100 * 60000);
        mismatches++;
        complete_run();
    end
    initial begin
        reset = 1'b1;
        port_wr = '0;
        ram_req = '0;
        ovf_ack = 2'h0;
        pin_mode = 2'h0;
        repeat (10) @(negedge sys_clk);
        reset = 1'b0;
        `CHK("pin_used", 2'h0, pin_used)
        for (int k = 0; k < 8; k++) begin
            ram_read(k[2:0], d);
            `CHK("nibble reset", 4'h0, d)
        end
        set_count(1'b0, 12'hA5C);
        set_count(1'b1, 12'h3B7);
        port_write(5'h1E, 4'hF);
        repeat (3000) @(negedge sys_clk);
        get_count(1'b0, v);
        `CHK("stopped one", 12'hA5C, v)
        get_count(1'b1, v);
        `CHK("stopped two", 12'h3B7, v)
        ram_write(3'h3, 4'hF);
        ram_read(3'h3, d);
        `CHK("nibble three", 4'h0, d)
        $display("test storage done");

        set_count(1'b0, 12'hFFF); // one pulse to wrap
        set_count(1'b1, 12'hFFF);
        port_write(`DTC_ADDR_CTRL_ONE, 4'h8);
        port_write(`DTC_ADDR_CTRL_TWO, 4'h8);
        `CHK("pin_used timer", 2'h0, pin_used)
        wait_on(0, 1200);
        wait_on(1, 20);
        `CHK("overflow gap", 8, t)
        get_count(1'b0, v);
        `CHK("wrap one", 12'h000, v)
        get_count(1'b1, v);
        `CHK("wrap two", 12'h000, v)
        repeat (20) @(negedge sys_clk);
        `CHK("ovf held", 2'h3, ovf_irq)
        ovf_ack = 2'h3;
        @(negedge sys_clk);
        ovf_ack = 2'h0;
        `CHK("ovf cleared", 2'h0, ovf_irq)
        wait_on(2, 1100);
        wait_on(4, 40);
        `CHK("stall span", 16, t)
        get_count(1'b0, v);
        `CHK("after wrap one", 12'h001, v)
        get_count(1'b1, v);
        `CHK("after wrap two", 12'h001, v)
        port_write(`DTC_ADDR_CTRL_ONE, 4'h0);
        port_write(`DTC_ADDR_CTRL_TWO, 4'h0);
        $display("test timer done");

        set_count(1'b0, 12'h000);
        set_count(1'b1, 12'h000);
        port_write(`DTC_ADDR_CTRL_ONE, 4'h4);
        port_write(`DTC_ADDR_CTRL_TWO, 4'h4);
        `CHK("pin_used event", 2'h2, pin_used)
        r0 = rises;
        pin_mode <= 2'h2;
        repeat (640) @(negedge sys_clk);
        pin_mode <= 2'h0;
        repeat (60) @(negedge sys_clk);
        get_count(1'b1, v);
        `CHK("events", rises - r0, v[7:0])
        get_count(1'b0, v);
        `CHK("no first pin", 12'h000, v)
        // start from zero so the event count cannot hide a dead pulse mode
        set_count(1'b1, 12'h000);
        port_write(`DTC_ADDR_CTRL_TWO, 4'hC);
        pin_mode <= 2'h1;
        repeat (3500) @(negedge sys_clk);
        pin_mode <= 2'h0;
        repeat (60) @(negedge sys_clk);
        get_count(1'b1, v);
        `CHK("width counted", 1'b1, v >= 12'h003 && v <= 12'h004)
        repeat (2500) @(negedge sys_clk);
        get_count(1'b1, w);
        `CHK("width idle", v, w)
        port_write(`DTC_ADDR_CTRL_TWO, 4'h0);
        $display("test pin modes done");

        port_write(`DTC_ADDR_PERIODIC, 4'h8);
        wait_on(3, 1100);
        @(negedge sys_clk);
        wait_on(3, 1100);
        `CHK("periodic gap", 1023, t)
        port_write(`DTC_ADDR_PERIODIC, 4'h9);
        wait_on(3, 16400);
        @(negedge sys_clk);
        wait_on(3, 16400);
        `CHK("periodic slow gap", 16383, t)
        $display("test periodic done");
        complete_run();
    end
endmodule

bind dtc_timer_counter dtc_chk u_chk (.sys_clk(sys_clk), .reset(reset), .ram_req(ram_req),
    .ram_rdata(ram_rdata), .instr_end(instr_end), .instr_tick(instr_tick),
    .count_stall(count_stall), .pin_used(pin_used), .ovf_ack(ovf_ack), .ovf_irq(ovf_irq),
    .periodic_irq(periodic_irq));
`default_nettype wire
